// file: pixel_coprocessor_control_pkg.sv
// Constants and carriers for the pixel coprocessor control block.
// Assumes one clock, a synchronous reset and a pixel memory that
// answers each request with a one-cycle acknowledge.
//
// Overview of operation
// - Pattern from map A/B/C, constant one, or source.
// - Zero source gives background, nonzero gives foreground.
// - Source-derived pattern ignores pattern map contents.
// - Pattern one picks foreground source/mix, zero background.
// - Fixed colors expand one-bit pattern to pixel width.
// - Write mask disabled bits stay unwritten.
// - Narrow pixels use only low mask bits.
// - Masked bits excluded from mixing and compare.
// - Compare destination; true condition suppresses the write.
// - Codes: always, gt, eq, lt, never, ge, ne, le.
// - Writing pixel operation top byte starts operations.
// - Suspend finishes memory cycle, halts; clear resumes.
// - Suspended state readable; restore then restart possible.
// - Terminate aborts; advancing registers become undefined.
// - Completion always sets complete status bit.
// - Status cleared by writing one; host clears it.
// - Enabled completion also raises interrupt request.
// - Enables at 21x4, statuses at 21x5 per interrupt.
// - Busy reads one while executing, zero after.
// - Other writes while busy complete and flag rejection.
// - Control register writable while busy, no rejection.
package pixel_coprocessor_control_pkg;

  localparam int PIX_W = 8;
  localparam int CNT_W = 16;

  // Register indices seen on the host write port.
  localparam logic [7:0] REG_CONTROL = 8'h11;
  localparam logic [7:0] REG_PIXEL_OP = 8'h7C;
  localparam logic [7:0] REG_MIX = 8'h48;
  localparam logic [7:0] REG_CMP_VALUE = 8'h4C;
  localparam logic [7:0] REG_BIT_MASK = 8'h50;
  localparam logic [7:0] REG_FG_COLOR = 8'h58;
  localparam logic [7:0] REG_BG_COLOR = 8'h5C;
  localparam logic [7:0] REG_OP_DIM = 8'h60;
  localparam logic [7:0] REG_STATE_PORT = 8'h0C;
  localparam logic [7:0] REG_INT_ENABLE = 8'h14;
  localparam logic [7:0] REG_INT_STATUS = 8'h15;

  // Field positions.
  localparam int POP_PAT_LO = 8;
  localparam int POP_FG_SRC = 12;
  localparam int POP_BG_SRC = 13;
  localparam int POP_BPP_LO = 16;
  localparam int POP_START_BE = 3;
  localparam int MIX_FG_LO = 0;
  localparam int MIX_BG_LO = 8;
  localparam int MIX_COND_LO = 16;
  localparam int INT_DONE = 0;
  localparam int INT_REJECT = 1;

  // Reset values and the unit count step.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [PIX_W-1:0] RST_BIT_MASK = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic [3:0] {
    PAT_MAP_A = 4'h0,
    PAT_MAP_B = 4'h1,
    PAT_MAP_C = 4'h2,
    PAT_FG = 4'h8,
    PAT_FROM_SRC = 4'h9
  } pat_sel_t;

  typedef enum logic [2:0] {
    CMP_ALWAYS = 3'h0,
    CMP_GT = 3'h1,
    CMP_EQ = 3'h2,
    CMP_LT = 3'h3,
    CMP_NEVER = 3'h4,
    CMP_GE = 3'h5,
    CMP_NE = 3'h6,
    CMP_LE = 3'h7
  } cmp_cond_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_HALT = 2'b10
  } op_state_t;

  // Pixel fetched from memory for one memory cycle.
  typedef struct packed {
    logic [PIX_W-1:0] src;
    logic [PIX_W-1:0] dst;
    logic pat_a;
    logic pat_b;
    logic pat_c;
  } pix_in_t;

  // Pixel written back: data, per-bit write enables and its index.
  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic [PIX_W-1:0] wmask;
    logic [CNT_W-1:0] idx;
  } pix_out_t;

endpackage

// file: pixel_coprocessor_control.sv
// Pixel coprocessor control: operation sequencing, pattern generation,
// color expansion, bit masking, color compare and completion status.
// Assumes the host write port and the pixel memory are synchronous to
// I_SYS_CLK; the memory holds each acknowledge for one cycle only.
`timescale 1ns/1ps

module pixel_coprocessor_control #(
  parameter int PIX_W = pixel_coprocessor_control_pkg::PIX_W,
  parameter int CNT_W = pixel_coprocessor_control_pkg::CNT_W
) (
  // Clock and reset.
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  // Host register writes.
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_IDX,
  input wire logic [3:0] I_REG_BE,
  input wire logic [31:0] I_REG_DATA,
  // Control register fields as written.
  input wire logic I_CTL_SUSPEND,
  input wire logic I_CTL_TERMINATE,
  // Pixel memory.
  input wire logic I_PIX_ACK,
  input wire pixel_coprocessor_control_pkg::pix_in_t I_PIX_IN,
  output logic O_PIX_REQ,
  output logic O_PIX_WE,
  output pixel_coprocessor_control_pkg::pix_out_t O_PIX_OUT,
  // Status towards the host.
  output logic O_BUSY,
  output logic O_SUSPENDED,
  output logic [1:0] O_INT_STATUS,
  output logic O_IRQ,
  output logic [CNT_W-1:0] O_SAVE_COUNT
);

  initial begin
    if (PIX_W != 8 || CNT_W < 2 || CNT_W > 32) begin
      $error("pixel_coprocessor_control: unsupported PIX_W or CNT_W");
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Host-visible registers.

  logic [31:0] pixel_op;
  logic [31:0] mix_reg;
  logic [PIX_W-1:0] cmp_value;
  logic [PIX_W-1:0] bit_mask;
  logic [PIX_W-1:0] fg_color;
  logic [PIX_W-1:0] bg_color;
  logic [CNT_W-1:0] op_dim;
  logic [1:0] int_enable;
  pixel_coprocessor_control_pkg::op_state_t state;
  logic [CNT_W-1:0] remain;
  logic [CNT_W-1:0] pix_idx;
  logic busy;

  wire logic wr_ctl = I_REG_WR && I_REG_IDX == pixel_coprocessor_control_pkg::REG_CONTROL;
  wire logic wr_other = I_REG_WR && !wr_ctl;
  wire logic wr_start = I_REG_WR && I_REG_IDX == pixel_coprocessor_control_pkg::REG_PIXEL_OP
    && I_REG_BE[pixel_coprocessor_control_pkg::POP_START_BE];
  wire logic wr_restore = I_REG_WR && I_REG_IDX == pixel_coprocessor_control_pkg::REG_STATE_PORT;

  // The bit mask resets to all ones so that a fresh block writes whole pixels.
  // Writes during an operation still land, which may corrupt it.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      pixel_op <= pixel_coprocessor_control_pkg::RST_ZERO;
      mix_reg <= pixel_coprocessor_control_pkg::RST_ZERO;
      cmp_value <= '0;
      bit_mask <= pixel_coprocessor_control_pkg::RST_BIT_MASK;
      fg_color <= '0;
      bg_color <= '0;
      op_dim <= '0;
      int_enable <= 2'h0;
    end else if (wr_other) begin
      case (I_REG_IDX)
        pixel_coprocessor_control_pkg::REG_PIXEL_OP: pixel_op <= I_REG_DATA;
        pixel_coprocessor_control_pkg::REG_MIX: mix_reg <= I_REG_DATA;
        pixel_coprocessor_control_pkg::REG_CMP_VALUE: cmp_value <= I_REG_DATA[PIX_W-1:0];
        pixel_coprocessor_control_pkg::REG_BIT_MASK: bit_mask <= I_REG_DATA[PIX_W-1:0];
        pixel_coprocessor_control_pkg::REG_FG_COLOR: fg_color <= I_REG_DATA[PIX_W-1:0];
        pixel_coprocessor_control_pkg::REG_BG_COLOR: bg_color <= I_REG_DATA[PIX_W-1:0];
        pixel_coprocessor_control_pkg::REG_OP_DIM: op_dim <= I_REG_DATA[CNT_W-1:0];
        pixel_coprocessor_control_pkg::REG_INT_ENABLE: int_enable <= I_REG_DATA[1:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pixel datapath.

  pixel_coprocessor_control_pkg::pat_sel_t pat_sel;
  logic pattern;
  logic [PIX_W-1:0] width_mask;
  logic [PIX_W-1:0] eff_mask;
  logic [PIX_W-1:0] fg_src;
  logic [PIX_W-1:0] bg_src;
  logic [PIX_W-1:0] op_src;
  logic [7:0] op_mix;
  logic [PIX_W-1:0] mixed;
  logic [PIX_W-1:0] dst_m;
  logic [PIX_W-1:0] cmp_m;
  logic inhibit;
  logic [1:0] bpp_code;

  assign pat_sel = pixel_coprocessor_control_pkg::pat_sel_t'(
    pixel_op[pixel_coprocessor_control_pkg::POP_PAT_LO +: 4]);
  assign bpp_code = pixel_op[pixel_coprocessor_control_pkg::POP_BPP_LO +: 2];

  // Map contents are not looked at when the pattern comes from the source.
  always_comb begin
    case (pat_sel)
      pixel_coprocessor_control_pkg::PAT_MAP_A: pattern = I_PIX_IN.pat_a;
      pixel_coprocessor_control_pkg::PAT_MAP_B: pattern = I_PIX_IN.pat_b;
      pixel_coprocessor_control_pkg::PAT_MAP_C: pattern = I_PIX_IN.pat_c;
      pixel_coprocessor_control_pkg::PAT_FROM_SRC: pattern = |I_PIX_IN.src;
      default: pattern = 1'b1;
    endcase
  end

  // A fixed color per pattern value makes a two-entry expansion table.
  assign fg_src = pixel_op[pixel_coprocessor_control_pkg::POP_FG_SRC] ? I_PIX_IN.src : fg_color;
  assign bg_src = pixel_op[pixel_coprocessor_control_pkg::POP_BG_SRC] ? I_PIX_IN.src : bg_color;
  assign op_src = pattern ? fg_src : bg_src;
  assign op_mix = pattern ? mix_reg[pixel_coprocessor_control_pkg::MIX_FG_LO +: 8]
    : mix_reg[pixel_coprocessor_control_pkg::MIX_BG_LO +: 8];

  // Width code n selects 2**n bits: 1, 2, 4 or 8 bits per pixel.
  // Mix codes 0..F act per bit as a truth table on source and destination;
  // other codes leave the destination as it was.
  genvar b;
  generate
    for (b = 0; b < PIX_W; b++) begin : g_bit
      assign width_mask[b] = b < (1 << bpp_code);
      assign eff_mask[b] = bit_mask[b] & width_mask[b];
      assign mixed[b] = op_mix[7:4] != 4'h0 ? I_PIX_IN.dst[b]
        : op_mix[{~op_src[b], ~I_PIX_IN.dst[b]}];
    end
  endgenerate

  // Disabled bits are zeroed on both sides so they cannot sway the compare.
  assign dst_m = I_PIX_IN.dst & eff_mask;
  assign cmp_m = cmp_value & eff_mask;

  always_comb begin
    case (mix_reg[pixel_coprocessor_control_pkg::MIX_COND_LO +: 3])
      pixel_coprocessor_control_pkg::CMP_ALWAYS: inhibit = 1'b1;
      pixel_coprocessor_control_pkg::CMP_GT: inhibit = dst_m > cmp_m;
      pixel_coprocessor_control_pkg::CMP_EQ: inhibit = dst_m == cmp_m;
      pixel_coprocessor_control_pkg::CMP_LT: inhibit = dst_m < cmp_m;
      pixel_coprocessor_control_pkg::CMP_NEVER: inhibit = 1'b0;
      pixel_coprocessor_control_pkg::CMP_GE: inhibit = dst_m >= cmp_m;
      pixel_coprocessor_control_pkg::CMP_NE: inhibit = dst_m != cmp_m;
      pixel_coprocessor_control_pkg::CMP_LE: inhibit = dst_m <= cmp_m;
      default: inhibit = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Operation sequencer.

  pixel_coprocessor_control_pkg::op_state_t next_state;
  logic last_pix;
  logic finish;

  // Busy covers the halted state too, so a suspended operation still
  // flags host writes to anything but the control register.
  assign busy = state != pixel_coprocessor_control_pkg::ST_IDLE;
  assign last_pix = remain == pixel_coprocessor_control_pkg::CNT_ONE;
  assign finish = state == pixel_coprocessor_control_pkg::ST_REQ && I_PIX_ACK && last_pix;

  // A request already out is held until its acknowledge, so a suspend
  // never cuts a memory cycle in half.
  always_comb begin
    next_state = state;
    case (state)
      pixel_coprocessor_control_pkg::ST_IDLE: begin
        if (wr_start) begin
          next_state = pixel_coprocessor_control_pkg::ST_REQ;
        end else if (wr_restore) begin
          next_state = pixel_coprocessor_control_pkg::ST_HALT;
        end
      end
      pixel_coprocessor_control_pkg::ST_REQ: begin
        if (I_PIX_ACK && last_pix) begin
          next_state = pixel_coprocessor_control_pkg::ST_IDLE;
        end else if (I_PIX_ACK && I_CTL_SUSPEND) begin
          next_state = pixel_coprocessor_control_pkg::ST_HALT;
        end
      end
      pixel_coprocessor_control_pkg::ST_HALT: begin
        if (!I_CTL_SUSPEND) begin
          next_state = pixel_coprocessor_control_pkg::ST_REQ;
        end
      end
      default: next_state = pixel_coprocessor_control_pkg::ST_IDLE;
    endcase
    // Terminate overrides every other move, so a halted operation can be
    // dropped without resuming it first.
    if (wr_ctl && I_CTL_TERMINATE && state != pixel_coprocessor_control_pkg::ST_IDLE) begin
      next_state = pixel_coprocessor_control_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      state <= pixel_coprocessor_control_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The pixel counter is the operation's saved state; after a terminate
  // it is left wherever it stopped.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      remain <= '0;
      pix_idx <= '0;
    end else if (state == pixel_coprocessor_control_pkg::ST_IDLE && wr_start) begin
      remain <= op_dim + pixel_coprocessor_control_pkg::CNT_ONE;
      pix_idx <= '0;
    end else if (state == pixel_coprocessor_control_pkg::ST_IDLE && wr_restore) begin
      remain <= I_REG_DATA[CNT_W-1:0];
      pix_idx <= I_REG_DATA[31:32-CNT_W];
    end else if (state == pixel_coprocessor_control_pkg::ST_REQ && I_PIX_ACK) begin
      remain <= remain - pixel_coprocessor_control_pkg::CNT_ONE;
      pix_idx <= pix_idx + pixel_coprocessor_control_pkg::CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pixel write-back.

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_PIX_WE <= 1'b0;
      O_PIX_OUT <= '0;
    end else begin
      O_PIX_WE <= 1'b0;
      if (state == pixel_coprocessor_control_pkg::ST_REQ && I_PIX_ACK) begin
        O_PIX_WE <= !inhibit && eff_mask != '0;
        O_PIX_OUT.data <= (mixed & eff_mask) | (I_PIX_IN.dst & ~eff_mask);
        O_PIX_OUT.wmask <= eff_mask;
        O_PIX_OUT.idx <= pix_idx;
      end
    end
  end

  // A new request only starts from the halted state once suspend drops.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_PIX_REQ <= 1'b0;
    end else begin
      O_PIX_REQ <= next_state == pixel_coprocessor_control_pkg::ST_REQ;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status and interrupt.

  logic [1:0] int_status;
  logic [1:0] status_set;
  logic [1:0] status_clr;

  // Completion and rejection are independent events; both may land in one
  // cycle, and neither masks the other.
  assign status_set[pixel_coprocessor_control_pkg::INT_DONE] = finish;
  assign status_set[pixel_coprocessor_control_pkg::INT_REJECT] = wr_other && busy;
  // Clearing the status while busy is itself a rejected access.
  assign status_clr = (I_REG_WR && I_REG_IDX == pixel_coprocessor_control_pkg::REG_INT_STATUS)
    ? I_REG_DATA[1:0] : 2'h0;

  // A new event in the clearing cycle wins over the clear.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      int_status <= 2'h0;
    end else begin
      int_status <= (int_status & ~status_clr) | status_set;
    end
  end

  // Status outputs take the next internal values so that they leave flip-flops
  // without lag; O_SAVE_COUNT takes remain and trails it by one cycle.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_INT_STATUS <= 2'h0;
      O_IRQ <= 1'b0;
      O_BUSY <= 1'b0;
      O_SUSPENDED <= 1'b0;
      O_SAVE_COUNT <= '0;
    end else begin
      O_INT_STATUS <= (int_status & ~status_clr) | status_set;
      O_IRQ <= |(((int_status & ~status_clr) | status_set) & int_enable);
      O_BUSY <= next_state != pixel_coprocessor_control_pkg::ST_IDLE;
      O_SUSPENDED <= next_state == pixel_coprocessor_control_pkg::ST_HALT;
      O_SAVE_COUNT <= remain;
    end
  end

endmodule // pixel_coprocessor_control

// file: pixel_coprocessor_control_props.sv
// Port-level assertions for the pixel coprocessor control block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module pixel_coprocessor_control_props #(
  parameter int PIX_W = pixel_coprocessor_control_pkg::PIX_W,
  parameter int CNT_W = pixel_coprocessor_control_pkg::CNT_W
) (
  // Clock and reset.
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  // Host side.
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_IDX,
  input wire logic [3:0] I_REG_BE,
  input wire logic I_CTL_SUSPEND,
  input wire logic I_CTL_TERMINATE,
  // Memory and status.
  input wire logic I_PIX_ACK,
  input wire logic O_PIX_REQ,
  input wire logic O_PIX_WE,
  input wire pixel_coprocessor_control_pkg::pix_out_t O_PIX_OUT,
  input wire logic O_BUSY,
  input wire logic O_SUSPENDED,
  input wire logic [1:0] O_INT_STATUS,
  input wire logic O_IRQ
);
  logic ctl_wr;
  logic ctl_term;
  logic start_wr;
  assign ctl_wr = I_REG_WR && I_REG_IDX == pixel_coprocessor_control_pkg::REG_CONTROL;
  assign ctl_term = ctl_wr && I_CTL_TERMINATE;
  assign start_wr = I_REG_WR && I_REG_IDX == pixel_coprocessor_control_pkg::REG_PIXEL_OP;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  ////////////////////////////////////////////////////////////
  a_start_runs: assert property (start_wr && I_REG_BE[3] && !O_BUSY && !I_CTL_SUSPEND
    |=> O_BUSY && O_PIX_REQ) else $error("start write did not launch an operation");
  a_write_cause: assert property (O_PIX_WE
    |-> $past(I_PIX_ACK) && O_PIX_OUT.wmask != '0) else $error("pixel write without cause");
  a_done_status: assert property ($fell(O_BUSY) && !$past(ctl_term)
    |-> O_INT_STATUS[0]) else $error("completion did not set status");
  a_irq_cause: assert property (O_IRQ |-> O_INT_STATUS != 2'h0)
    else $error("interrupt without status");
  a_reject_flag: assert property (I_REG_WR && !ctl_wr && O_BUSY
    |-> ##[1:2] O_INT_STATUS[1]) else $error("busy write not flagged");
  a_ctl_quiet: assert property (ctl_wr && !O_INT_STATUS[1] && !$past(I_REG_WR)
    |=> !O_INT_STATUS[1]) else $error("control write flagged");
  a_halt_idle: assert property (O_SUSPENDED |-> O_BUSY && !O_PIX_REQ)
    else $error("suspended but still requesting");
  a_resume_req: assert property (O_SUSPENDED && !I_CTL_SUSPEND && !ctl_wr
    |-> ##[1:2] O_PIX_REQ) else $error("no resume after suspend cleared");
  a_req_busy: assert property (O_PIX_REQ |-> O_BUSY)
    else $error("request while not busy");
  a_term_stops: assert property (ctl_term && O_BUSY
    |=> !O_BUSY && !O_PIX_REQ && !$rose(O_INT_STATUS[0])) else $error("terminate failed");
endmodule // pixel_coprocessor_control_props

bind pixel_coprocessor_control pixel_coprocessor_control_props #(.PIX_W(PIX_W), .CNT_W(CNT_W))
  u_props (.I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .I_REG_WR(I_REG_WR), .I_REG_IDX(I_REG_IDX),
  .I_REG_BE(I_REG_BE), .I_CTL_SUSPEND(I_CTL_SUSPEND), .I_CTL_TERMINATE(I_CTL_TERMINATE),
  .I_PIX_ACK(I_PIX_ACK), .O_PIX_REQ(O_PIX_REQ), .O_PIX_WE(O_PIX_WE), .O_PIX_OUT(O_PIX_OUT),
  .O_BUSY(O_BUSY), .O_SUSPENDED(O_SUSPENDED), .O_INT_STATUS(O_INT_STATUS), .O_IRQ(O_IRQ));

// file: pixel_memory_model.sv
// Pixel memory model answering each request after a short or long wait.
// Assumes requests are held until acknowledged, one pixel per answer.
`timescale 1ns/1ps
module pixel_memory_model (
  // Clock and pacing.
  input wire logic i_clk,
  input wire logic i_slow,
  // Pixel contents.
  input wire logic [7:0] i_src,
  input wire logic [7:0] i_dst,
  input wire logic [2:0] i_pat,
  // Memory port.
  input wire logic i_req,
  output logic o_ack,
  output pixel_coprocessor_control_pkg::pix_in_t o_pix
);
  logic [1:0] wait_cnt = 2'h0;
  initial begin
    o_ack = 1'b0;
    o_pix = '0;
  end
  // Released data is inverted so that a late sample cannot match by luck.
  always @(posedge i_clk) begin
    #1;
    if (o_ack) begin
      o_ack = 1'b0;
      o_pix = ~o_pix;
    end else if (i_req && (!i_slow || wait_cnt == 2'h2)) begin
      o_ack = 1'b1;
      o_pix = {i_src, i_dst, i_pat};
      wait_cnt = 2'h0;
    end else if (i_req) begin
      wait_cnt = wait_cnt + 2'h1;
    end
  end
endmodule // pixel_memory_model

// file: pixel_coprocessor_control_tb.sv
// Self-checking bench for the pixel coprocessor control block.
// Assumes the memory model is the only answerer of pixel requests.
`timescale 1ns/1ps
module pixel_coprocessor_control_tb;
  logic I_SYS_CLK = 1'b0;
  logic I_SRST = 1'b1;
  logic I_REG_WR = 1'b0;
  logic [7:0] I_REG_IDX = 8'h00;
  logic [3:0] I_REG_BE = 4'h0;
  logic [31:0] I_REG_DATA = 32'h0000_0000;
  logic I_CTL_SUSPEND = 1'b0;
  logic I_CTL_TERMINATE = 1'b0;
  logic I_PIX_ACK, O_PIX_REQ, O_PIX_WE, O_BUSY, O_SUSPENDED, O_IRQ;
  pixel_coprocessor_control_pkg::pix_in_t I_PIX_IN;
  pixel_coprocessor_control_pkg::pix_out_t O_PIX_OUT;
  logic [1:0] O_INT_STATUS;
  logic [15:0] O_SAVE_COUNT, last_idx;
  logic [7:0] m_src = 8'h00, m_dst = 8'h00, last_data;
  logic [2:0] m_pat = 3'h0;
  logic slow = 1'b0;
  logic [3:0] sels [4] = '{4'h0, 4'h1, 4'h2, 4'h8};
  logic [7:0] exp_c [4] = '{8'hA5, 8'h3C, 8'hA5, 8'hA5};
  int n_we = 0, fails = 0, n_compared = 0, cycles = 0;
  pixel_coprocessor_control dut (.I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .I_REG_WR(I_REG_WR),
    .I_REG_IDX(I_REG_IDX), .I_REG_BE(I_REG_BE), .I_REG_DATA(I_REG_DATA),
    .I_CTL_SUSPEND(I_CTL_SUSPEND), .I_CTL_TERMINATE(I_CTL_TERMINATE), .I_PIX_ACK(I_PIX_ACK),
    .I_PIX_IN(I_PIX_IN), .O_PIX_REQ(O_PIX_REQ), .O_PIX_WE(O_PIX_WE), .O_PIX_OUT(O_PIX_OUT),
    .O_BUSY(O_BUSY), .O_SUSPENDED(O_SUSPENDED), .O_INT_STATUS(O_INT_STATUS), .O_IRQ(O_IRQ),
    .O_SAVE_COUNT(O_SAVE_COUNT));
  pixel_memory_model u_mem (.i_clk(I_SYS_CLK), .i_slow(slow), .i_src(m_src), .i_dst(m_dst),
    .i_pat(m_pat), .i_req(O_PIX_REQ), .o_ack(I_PIX_ACK), .o_pix(I_PIX_IN));
  ////////////////////////////////////////////////////////////
  initial begin
    forever #5 I_SYS_CLK = ~I_SYS_CLK;
  end
  always @(posedge I_SYS_CLK) begin
    cycles <= cycles + 1;
    if (O_PIX_WE === 1'b1) begin
      n_we <= n_we + 1;
      last_data <= O_PIX_OUT.data;
      last_idx <= O_PIX_OUT.idx;
    end
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  function automatic logic hit(input logic [2:0] c, input logic [7:0] d);
    case (c)
      3'h0: hit = 1'b1;
      3'h1: hit = d > 8'h40;
      3'h2: hit = d == 8'h40;
      3'h3: hit = d < 8'h40;
      3'h4: hit = 1'b0;
      3'h5: hit = d >= 8'h40;
      3'h6: hit = d != 8'h40;
      default: hit = d <= 8'h40;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_SYS_CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] data, input logic tm = 1'b0);
    I_REG_IDX = idx;
    I_REG_DATA = data;
    I_REG_BE = 4'hF;
    I_CTL_TERMINATE = tm;
    I_REG_WR = 1'b1;
    tick(1);
    I_REG_WR = 1'b0;
    I_CTL_TERMINATE = 1'b0;
    tick(1);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 200 && O_BUSY !== 1'b0; k++) tick(1);
    tick(1);
    chk(O_BUSY, 1'b0);
  endtask
  task automatic op(input logic [3:0] sel, input logic [1:0] w, input logic [7:0] s,
      input logic [7:0] d, input logic [2:0] p, input logic [3:0] fl = 4'h0);
    m_src = s;
    m_dst = d;
    m_pat = p;
    n_we = 0;
    wr(pixel_coprocessor_control_pkg::REG_PIXEL_OP, {14'h0000, w, fl, sel, 8'h00});
    wait_idle();
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    tick(3);
    I_SRST = 1'b0;
    chk({O_BUSY, O_PIX_REQ, O_INT_STATUS, O_IRQ}, 5'h00);
    wr(pixel_coprocessor_control_pkg::REG_INT_ENABLE, 32'h0000_0003);
    wr(pixel_coprocessor_control_pkg::REG_MIX, 32'h0004_0303);
    wr(pixel_coprocessor_control_pkg::REG_FG_COLOR, 32'h0000_00A5);
    wr(pixel_coprocessor_control_pkg::REG_BG_COLOR, 32'h0000_003C);
    op(4'h9, 2'h3, 8'h00, 8'h11, 3'h7);
    chk(last_data, 8'h3C);
    op(4'h9, 2'h3, 8'h07, 8'h11, 3'h0);
    chk(last_data, 8'hA5);
    chk({O_INT_STATUS[0], O_IRQ}, 2'h3);
    wr(pixel_coprocessor_control_pkg::REG_INT_STATUS, 32'h0000_0001);
    chk({O_INT_STATUS, O_IRQ}, 3'h0);
    for (int i = 0; i < 4; i++) begin
      op(sels[i], 2'h3, 8'h00, 8'h11, 3'h5);
      chk(last_data, exp_c[i]);
    end
    wr(pixel_coprocessor_control_pkg::REG_MIX, 32'h0004_0503);
    op(4'h0, 2'h3, 8'h6B, 8'h11, 3'h4, 4'h1);
    chk(last_data, 8'h6B);
    op(4'h1, 2'h3, 8'h6B, 8'h11, 3'h4, 4'h1);
    chk(last_data, 8'h11);
    wr(pixel_coprocessor_control_pkg::REG_BIT_MASK, 32'h0000_00F3);
    wr(pixel_coprocessor_control_pkg::REG_FG_COLOR, 32'h0000_0000);
    op(4'h8, 2'h2, 8'h00, 8'h5A, 3'h0);
    chk({last_data, O_PIX_OUT.wmask}, 16'h5803);
    wr(pixel_coprocessor_control_pkg::REG_BIT_MASK, 32'h0000_0003);
    wr(pixel_coprocessor_control_pkg::REG_CMP_VALUE, 32'h0000_0007);
    wr(pixel_coprocessor_control_pkg::REG_MIX, 32'h0002_0303);
    op(4'h8, 2'h3, 8'h00, 8'hF3, 3'h0);
    chk(n_we, 0);
    wr(pixel_coprocessor_control_pkg::REG_BIT_MASK, 32'h0000_00FF);
    wr(pixel_coprocessor_control_pkg::REG_CMP_VALUE, 32'h0000_0040);
    for (int c = 0; c < 8; c++) begin
      wr(pixel_coprocessor_control_pkg::REG_MIX, {13'h0000, c[2:0], 16'h0303});
      for (int j = 0; j < 3; j++) begin
        op(4'h8, 2'h3, 8'h00, 8'h3F + j[7:0], 3'h0);
        chk(n_we, !hit(c[2:0], 8'h3F + j[7:0]));
      end
    end
    wr(pixel_coprocessor_control_pkg::REG_MIX, 32'h0004_0303);
    wr(pixel_coprocessor_control_pkg::REG_OP_DIM, 32'h0000_0003);
    slow = 1'b1;
    n_we = 0;
    wr(pixel_coprocessor_control_pkg::REG_PIXEL_OP, 32'h0003_0800);
    for (int k = 0; k < 50 && n_we == 0; k++) tick(1);
    I_CTL_SUSPEND = 1'b1;
    chk(O_BUSY, 1'b1);
    for (int k = 0; k < 50 && O_SUSPENDED !== 1'b1; k++) tick(1);
    tick(2);
    chk({O_SUSPENDED, O_PIX_REQ, n_we[3:0], O_SAVE_COUNT}, 22'h22_0002);
    wr(pixel_coprocessor_control_pkg::REG_CONTROL, 32'h0000_0000);
    chk(O_INT_STATUS[1], 1'b0);
    wr(pixel_coprocessor_control_pkg::REG_FG_COLOR, 32'h0000_0000);
    tick(1);
    chk({O_INT_STATUS[1], O_IRQ}, 2'h3);
    I_CTL_SUSPEND = 1'b0;
    wait_idle();
    chk({n_we[3:0], last_idx}, 20'h4_0003);
    wr(pixel_coprocessor_control_pkg::REG_INT_STATUS, 32'h0000_0003);
    wr(pixel_coprocessor_control_pkg::REG_OP_DIM, 32'h0000_0020);
    wr(pixel_coprocessor_control_pkg::REG_PIXEL_OP, 32'h0003_0800);
    tick(4);
    wr(pixel_coprocessor_control_pkg::REG_CONTROL, 32'h0000_0000, 1'b1);
    chk({O_BUSY, O_PIX_REQ, O_INT_STATUS}, 4'h0);
    slow = 1'b0;
    n_we = 0;
    wr(pixel_coprocessor_control_pkg::REG_STATE_PORT, 32'h0005_0001);
    wait_idle();
    chk({n_we[3:0], last_idx}, 20'h1_0005);
    stop_test();
  end
endmodule // pixel_coprocessor_control_tb
